// file: hdl/fp_ctrl_pkg.sv
// shared constants and carriers for the floating point control word
package fp_ctrl_pkg;
   localparam int          WORD_W    = 32;
   // first layout: bit positions
   localparam int          A_DIS     = 0;
   localparam int          A_EXC     = 1;
   localparam int          A_ASYNC   = 2;
   localparam int          A_BK_SRC2 = 4;
   localparam int          A_BK_SRC1 = 5;
   localparam int          A_BK_DST  = 6;
   localparam int          A_PREM    = 7;
   localparam logic [31:0] A_WMASK   = 32'h0000_00f7;
   localparam logic [31:0] A_RESET   = 32'h0000_0000;
   // second layout: bit positions
   localparam int          B_RUP     = 31;
   localparam int          B_IE      = 28;
   localparam int          B_MOVF    = 27;
   localparam int          B_EOVF    = 26;
   localparam int          B_OPH_HI  = 23;
   localparam int          B_OPH_LO  = 20;
   localparam int          B_PRH     = 19;
   localparam int          B_SRC1_HI = 18;
   localparam int          B_SRC1_LO = 16;
   localparam int          B_OPM     = 15;
   localparam int          B_DST_HI  = 14;
   localparam int          B_DST_LO  = 12;
   localparam int          B_SYNC    = 11;
   localparam int          B_ASYNC   = 10;
   localparam int          B_RND     = 9;
   localparam int          B_EN      = 8;
   localparam int          B_PRL     = 7;
   localparam int          B_RMD_HI  = 6;
   localparam int          B_RMD_LO  = 5;
   localparam int          B_OPL     = 4;
   localparam int          B_SRC2_HI = 3;
   localparam int          B_SRC2_LO = 0;
   localparam logic [31:0] B_WMASK   = 32'h0000_0100;
   localparam logic [31:0] B_RESET   = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // one coprocessor register transfer from the core
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              user_mode;
      logic [WORD_W-1:0] wdata;
   } xfer_req_t;

   // answer to a transfer, one cycle later
   typedef struct packed {
      logic              done;
      logic              trap;
      logic [WORD_W-1:0] rdata;
   } xfer_rsp_t;

   // first layout events from the arithmetic hardware
   typedef struct packed {
      logic rem_valid;
      logic rem_partial;
      logic exc_valid;
      logic exc_async;
   } a_event_t;

   // second layout bounce report from the arithmetic unit
   typedef struct packed {
      logic       valid;
      logic       sync;
      logic       rounding_stage;
      logic       rounded_up;
      logic       inexact;
      logic       mant_ovf;
      logic       exp_ovf;
      logic [5:0] opcode;
      logic [1:0] prec;
      logic [2:0] src1;
      logic [2:0] dest;
      logic [1:0] round_mode;
      logic [3:0] src2;
   } bounce_t;
endpackage

// file: hdl/fp_control_status_register.sv
// floating point control word with two build-time layouts
module fp_control_status_register
   import fp_ctrl_pkg::*;
#(
   parameter bit LAYOUT_B = 1'b0
) (
   input  wire logic      core_clk,
   input  wire logic      rst_n,
   input  wire xfer_req_t req,
   input  wire a_event_t  a_evt,
   input  wire bounce_t   bounce,
   output xfer_rsp_t      rsp_ff,
   output logic           hw_disable_ff
);

   logic [WORD_W-1:0] ctrl_ff;
   logic [WORD_W-1:0] nxt_ctrl;
   xfer_rsp_t         nxt_rsp;
   logic              nxt_hw_disable;
   logic              legal;
   logic              rd;
   logic              wr;

   // masked merge of a written word into the stored one
   function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old_w,
                                                    input logic [WORD_W-1:0] new_w,
                                                    input logic [WORD_W-1:0] mask);
      merge_word = (old_w & ~mask) | (new_w & mask);
   endfunction

   // bounce report laid out as the second layout word, enable left zero
   function automatic logic [WORD_W-1:0] pack_bounce(input bounce_t b);
      logic [WORD_W-1:0] w;
      w = WORD_ZERO;
      w[B_RUP]  = b.rounded_up;
      w[B_IE]   = b.inexact;
      w[B_MOVF] = b.mant_ovf;
      w[B_EOVF] = b.exp_ovf;
      if (b.sync) begin
         // opcode stays zero: support code decodes it from the link register
         w[B_SYNC] = 1'b1;
      end else begin
         w[B_ASYNC]             = 1'b1;
         w[B_RND]               = b.rounding_stage;
         w[B_OPH_HI:B_OPH_LO]   = b.opcode[5:2];
         w[B_OPM]               = b.opcode[1];
         w[B_OPL]               = b.opcode[0];
         w[B_PRH]               = b.prec[1];
         w[B_PRL]               = b.prec[0];
         w[B_SRC1_HI:B_SRC1_LO] = b.src1;
         w[B_DST_HI:B_DST_LO]   = b.dest;
         w[B_RMD_HI:B_RMD_LO]   = b.round_mode;
         w[B_SRC2_HI:B_SRC2_LO] = b.src2; // bit 3 set means a constant operand
      end
      pack_bounce = w;
   endfunction

   // privilege check: user mode never reaches the register
   assign legal = req.valid && !req.user_mode;
   assign rd    = legal && !req.write;
   assign wr    = legal && req.write;

   // next register value; the unused layout folds away on the constant
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (!LAYOUT_B) begin
         if (wr) begin
            nxt_ctrl = merge_word(ctrl_ff, req.wdata, A_WMASK);
         end
         if (a_evt.rem_valid) begin
            nxt_ctrl[A_PREM] = a_evt.rem_partial;
         end
         // a hardware exception wins over a write clearing the flag
         if (a_evt.exc_valid) begin
            nxt_ctrl[A_EXC]   = 1'b1;
            nxt_ctrl[A_ASYNC] = a_evt.exc_async;
         end
         nxt_ctrl = nxt_ctrl & A_WMASK;
      end else begin
         if (rd) begin
            nxt_ctrl[B_SYNC]  = 1'b0;
            nxt_ctrl[B_ASYNC] = 1'b0;
         end
         if (wr) begin
            nxt_ctrl = merge_word(nxt_ctrl, req.wdata, B_WMASK);
         end
         // a bounce in the read cycle is kept: set wins over read clear
         if (bounce.valid) begin
            nxt_ctrl = (nxt_ctrl & B_WMASK) | pack_bounce(bounce);
         end
      end
   end

   // answer: read data is the value before any read side effect
   always_comb begin
      nxt_rsp.done  = req.valid;
      nxt_rsp.trap  = req.valid && req.user_mode;
      nxt_rsp.rdata = rd ? ctrl_ff : WORD_ZERO;
      if (LAYOUT_B) begin
         nxt_hw_disable = !nxt_ctrl[B_EN];
      end else begin
         nxt_hw_disable = nxt_ctrl[A_DIS];
      end
   end

   // registers; bank selects drive the register file outside via rdata only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_ff       <= LAYOUT_B ? B_RESET : A_RESET;
         rsp_ff        <= '0;
         hw_disable_ff <= LAYOUT_B;
      end else begin
         ctrl_ff       <= nxt_ctrl;
         rsp_ff        <= nxt_rsp;
         hw_disable_ff <= nxt_hw_disable;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_user_access;
      req.valid && req.user_mode;
   endsequence

   sequence s_trap_answer;
      rsp_ff.done && rsp_ff.trap && (rsp_ff.rdata == WORD_ZERO);
   endsequence

   sequence s_quiet_read;
      LAYOUT_B && rd && !bounce.valid;
   endsequence

   a_user_trap_answer: assert property (s_user_access |=> s_trap_answer)
      else $error("user mode access did not trap");

   a_user_no_effect: assert property ((s_user_access and (!a_evt.rem_valid && !a_evt.exc_valid
                                      && !bounce.valid)) |=> $stable(ctrl_ff))
      else $error("user mode access changed the register");

   a_a_reserved_zero: assert property (!LAYOUT_B |-> (ctrl_ff & ~A_WMASK) == WORD_ZERO)
      else $error("reserved bits not zero");

   a_a_write_ignore: assert property (!LAYOUT_B && wr && !a_evt.rem_valid && !a_evt.exc_valid
                                      |=> ctrl_ff == ($past(req.wdata) & A_WMASK))
      else $error("first layout write stored wrong value");

   a_a_partial_rem: assert property (!LAYOUT_B && a_evt.rem_valid
                                     |=> ctrl_ff[A_PREM] == $past(a_evt.rem_partial))
      else $error("partial remainder bit wrong");

   a_a_bank_select: assert property (!LAYOUT_B && wr |=> ctrl_ff[A_BK_DST:A_BK_SRC2]
                                     == $past(req.wdata[A_BK_DST:A_BK_SRC2]))
      else $error("bank selects not written");

   a_a_exc_record: assert property (!LAYOUT_B && a_evt.exc_valid |=> ctrl_ff[A_EXC]
                                    && ctrl_ff[A_ASYNC] == $past(a_evt.exc_async))
      else $error("exception not recorded");

   a_a_disable_out: assert property (!LAYOUT_B |-> hw_disable_ff == ctrl_ff[A_DIS])
      else $error("disable output mismatch");

   a_b_read_clear: assert property (s_quiet_read |=> !ctrl_ff[B_SYNC]
                                    && !ctrl_ff[B_ASYNC] && rsp_ff.rdata == $past(ctrl_ff))
      else $error("read did not clear bounce flags");

   a_b_write_only_en: assert property (LAYOUT_B && wr && !bounce.valid |=> ctrl_ff
                  == merge_word($past(ctrl_ff), $past(req.wdata), B_WMASK))
      else $error("write touched bits other than enable");

   a_reset_disabled: assert property (disable iff (1'b0) $rose(rst_n)
                  |-> ctrl_ff == WORD_ZERO && hw_disable_ff == LAYOUT_B)
      else $error("register not cleared by reset");

   a_b_async_capture: assert property (LAYOUT_B && bounce.valid && !bounce.sync
                  |=> ctrl_ff[B_ASYNC] && ctrl_ff[B_RUP] == $past(bounce.rounded_up)
                  && ctrl_ff[B_OPH_HI:B_OPH_LO] == $past(bounce.opcode[5:2])
                  && ctrl_ff[B_RND] == $past(bounce.rounding_stage))
      else $error("async bounce capture wrong");

   a_b_sync_bounce: assert property (LAYOUT_B && bounce.valid && bounce.sync
                  |=> ctrl_ff[B_SYNC] && !ctrl_ff[B_ASYNC] && !ctrl_ff[B_RND]
                  && ctrl_ff[B_OPH_HI:B_OPH_LO] == 4'h0)
      else $error("sync bounce report wrong");

   // flags are reported for both bounce kinds, so check them apart from the fields
   a_b_flag_capture: assert property (LAYOUT_B && bounce.valid
                  |=> ctrl_ff[B_IE] == $past(bounce.inexact)
                  && ctrl_ff[B_MOVF] == $past(bounce.mant_ovf)
                  && ctrl_ff[B_EOVF] == $past(bounce.exp_ovf))
      else $error("bounce flags not captured");

   // on an async bounce every split field lands where support code looks for it
   a_b_field_capture: assert property (LAYOUT_B && bounce.valid && !bounce.sync
                  |=> ctrl_ff[B_SRC1_HI:B_SRC1_LO] == $past(bounce.src1)
                  && ctrl_ff[B_DST_HI:B_DST_LO] == $past(bounce.dest)
                  && ctrl_ff[B_RMD_HI:B_RMD_LO] == $past(bounce.round_mode)
                  && ctrl_ff[B_SRC2_HI:B_SRC2_LO] == $past(bounce.src2)
                  && {ctrl_ff[B_PRH], ctrl_ff[B_PRL]} == $past(bounce.prec)
                  && {ctrl_ff[B_OPM], ctrl_ff[B_OPL]} == $past(bounce.opcode[1:0]))
      else $error("async bounce fields wrong");

   // a bounce must not switch the hardware on or off behind software's back
   a_b_enable_kept: assert property (LAYOUT_B && bounce.valid && !wr
                  |=> ctrl_ff[B_EN] == $past(ctrl_ff[B_EN]))
      else $error("bounce changed the enable bit");

   a_b_disable_out: assert property (LAYOUT_B |-> hw_disable_ff == !ctrl_ff[B_EN])
      else $error("disable output does not follow enable");

   a_a_read_data: assert property (!LAYOUT_B && rd |=> rsp_ff.rdata == $past(ctrl_ff))
      else $error("first layout read data wrong");

endmodule

// file: bench/core_xfer_model.sv
// core side model issuing control word transfers
module core_xfer_model
   import fp_ctrl_pkg::*;
(
   input  wire xfer_rsp_t rsp,
   input  wire logic      core_clk,
   output xfer_req_t      req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req = '0;

   // one transfer: request stands until its taking edge, answer read 1ns after that same edge
   // data is passed as given, so the caller decides whether unused bits are zero
   task automatic xfer(input  logic              w,
                       input  logic              u,
                       input  logic [WORD_W-1:0] d,
                       output xfer_rsp_t         r);
      @(posedge core_clk);
      req <= '{valid: 1'b1, write: w, user_mode: u, wdata: d};
      @(posedge core_clk);
      // released fields show the inverse, never a stale copy
      req <= '{valid: 1'b0, write: ~w, user_mode: ~u, wdata: ~d};
      #1 r = rsp;
   endtask
endmodule

// file: bench/tb.sv
// self-checking bench for both control word layouts
module tb
   import fp_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic      core_clk = 1'b0;
   logic      rst_n    = 1'b0;
   a_event_t  a_evt    = '0;
   bounce_t   bnc      = '0;
   xfer_req_t req_a;
   xfer_req_t req_b;
   xfer_rsp_t rsp_a;
   xfer_rsp_t rsp_b;
   logic      dis_a;
   logic      dis_b;
   int        num_errors      = 0;
   int        samples_checked = 0;

   always #12.5 core_clk = ~core_clk;

   fp_control_status_register #(.LAYOUT_B(1'b0)) i_fp_control_status_register (
      .core_clk(core_clk), .rst_n(rst_n), .req(req_a), .a_evt(a_evt), .bounce(bnc),
      .rsp_ff(rsp_a), .hw_disable_ff(dis_a));
   // second build of the same block, other layout
   fp_control_status_register #(.LAYOUT_B(1'b1)) i_fp_control_status_register_b (
      .core_clk(core_clk), .rst_n(rst_n), .req(req_b), .a_evt(a_evt), .bounce(bnc),
      .rsp_ff(rsp_b), .hw_disable_ff(dis_b));
   core_xfer_model i_core_xfer_model_a (.core_clk(core_clk), .rsp(rsp_a), .req(req_a));
   core_xfer_model i_core_xfer_model_b (.core_clk(core_clk), .rsp(rsp_b), .req(req_b));

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", n, exp, got);
         num_errors++;
      end
   endtask

   // one transfer through the chosen core model, answer strobe always expected
   task automatic xf(input bit b, input logic w, input logic u, input logic [31:0] d,
                     output xfer_rsp_t r);
      if (b)
         i_core_xfer_model_b.xfer(w, u, d, r);
      else
         i_core_xfer_model_a.xfer(w, u, d, r);
      chk("done", 32'h1, {31'h0, r.done});
   endtask

   task automatic rd(input bit b, input logic [31:0] exp);
      xfer_rsp_t r;
      xf(b, 1'b0, 1'b0, WORD_ZERO, r);
      chk("rdata", exp, r.rdata);
      chk("trap", 32'h0, {31'h0, r.trap});
   endtask

   task automatic t_reset();
      rd(1'b0, 32'h0000_0000);
      chk("dis_a", 32'h0, {31'h0, dis_a});
      rd(1'b1, 32'h0000_0000);
      chk("dis_b", 32'h1, {31'h0, dis_b});
   endtask

   task automatic t_a_write();
      xfer_rsp_t r;
      xf(1'b0, 1'b1, 1'b0, 32'hffff_ffff, r);
      chk("dis_a", 32'h1, {31'h0, dis_a});
      rd(1'b0, 32'h0000_00f7);
      xf(1'b0, 1'b1, 1'b0, 32'h0000_0000, r);
      chk("dis_a", 32'h0, {31'h0, dis_a});
   endtask

   task automatic t_a_events();
      @(posedge core_clk);
      a_evt <= '{rem_valid: 1'b1, rem_partial: 1'b1, exc_valid: 1'b1, exc_async: 1'b1};
      @(posedge core_clk);
      a_evt <= '0;
      rd(1'b0, 32'h0000_0086);
   endtask

   // user mode access is refused both ways and leaves the word alone
   task automatic t_trap();
      xfer_rsp_t r;
      xf(1'b0, 1'b1, 1'b1, 32'h0000_00ff, r);
      chk("trap", 32'h1, {31'h0, r.trap});
      xf(1'b0, 1'b0, 1'b1, WORD_ZERO, r);
      chk("trap", 32'h1, {31'h0, r.trap});
      chk("rdata", 32'h0, r.rdata);
      rd(1'b0, 32'h0000_0086);
   endtask

   // inexact and exponent flags follow the bounce kind so each flag sees both levels
   task automatic pulse_bounce(input logic s);
      @(posedge core_clk);
      bnc <= '{1'b1, s, 1'b1, 1'b1, s, 1'b1, s, 6'h2d, 2'h2, 3'h3, 3'h5, 2'h2, 4'h9};
      @(posedge core_clk);
      bnc <= '0;
   endtask

   task automatic t_b_bounce();
      pulse_bounce(1'b0);
      rd(1'b1, 32'h88bb_5659);
      rd(1'b1, 32'h88bb_5259);
      pulse_bounce(1'b1);
      rd(1'b1, 32'h9c00_0800);
      rd(1'b1, 32'h9c00_0000);
   endtask

   task automatic t_b_write();
      xfer_rsp_t r;
      xf(1'b1, 1'b1, 1'b0, 32'h0000_0100, r);
      chk("dis_b", 32'h0, {31'h0, dis_b});
      rd(1'b1, 32'h9c00_0100);
      xf(1'b1, 1'b1, 1'b0, 32'h0000_0000, r);
      chk("dis_b", 32'h1, {31'h0, dis_b});
   endtask

   // a hang ends the run as a mismatch
   initial begin
      #100us;
      num_errors++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_a_write();
      t_a_events();
      t_trap();
      t_b_bounce();
      t_b_write();
      stop_test();
   end
endmodule
